/* core/ocd_decode.sv */
/*
 oscillator configuration decoder: captures the programmed configuration
 word after reset and drives steady oscillator and divider controls.
 assumes cfg_word_i is a static level from the configuration store,
 and a register master with one-cycle read and write strobes.
*/
// What this block does
// - switch/monitor field gates switching and fail-safe
// - bus divisor codes give 1,2,4,8
// - clock output only when primary off/external
// - primary mode: off, fast, standard, external
// - switchover bit enables two-speed start-up
// - secondary oscillator follows its enable bit
// - upper source codes pick rc/secondary sources
// - lower source codes pick primary/fast rc
`timescale 1ns/1ps
module ocd_decode
   import ocd_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // configuration store
   input wire logic [31:0] cfg_word_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // decoded controls
   output ocd_pkg::ocd_ctrl_s ctrl_o,
   output logic cfg_valid_o
);
   import ocd_pkg::*;

   // -----------------------------------------------------------------
   // capture
   // -----------------------------------------------------------------
   // the word is a pin-level input, so it is synchronised before use
   logic [31:0] cfg_s1_q;
   logic [31:0] cfg_s2_q;
   logic [31:0] cfg_q;
   logic [1:0] settle_q;
   logic [1:0] settle_d;
   logic cfg_valid_q;
   logic take;

   assign take = (settle_q == 2'h2) && !cfg_valid_q;
   assign settle_d = (settle_q == 2'h2) ? settle_q : settle_q + 2'h1;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_s1_q <= 32'h0000_0000;
         cfg_s2_q <= 32'h0000_0000;
      end else begin
         cfg_s1_q <= cfg_word_i;
         cfg_s2_q <= cfg_s1_q;
      end
   end

   // word is caught once after release and frozen until next reset
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         settle_q <= 2'h0;
         cfg_valid_q <= 1'b0;
         cfg_q <= 32'h0000_0000;
      end else begin
         settle_q <= settle_d;
         if (take) begin
            cfg_valid_q <= 1'b1;
            cfg_q <= cfg_s2_q;
         end
      end
   end

   // -----------------------------------------------------------------
   // field decode
   // -----------------------------------------------------------------
   // primary mode code to its flags, ordered {off, hs, xt, ext}
   function automatic logic [3:0] posc_flags(input logic [1:0] code);
      logic [3:0] flags;
      flags = 4'h0;
      unique case (code)
         OCD_POSC_OFF: flags = 4'h8;
         OCD_POSC_HS: flags = 4'h4;
         OCD_POSC_XT: flags = 4'h2;
         OCD_POSC_EXT: flags = 4'h1;
      endcase
      return flags;
   endfunction

   // source code to its lane toward the clock mux
   function automatic logic [7:0] src_lane(input logic [2:0] code);
      logic [7:0] lane;
      lane = 8'h00;
      for (int n = 0; n < 8; n++) begin
         lane[n] = (code == n[2:0]);
      end
      return lane;
   endfunction

   // raw fields of the captured word
   wire logic [1:0] f_csm = cfg_q[CSM_LSB +: 2];
   wire logic [1:0] f_pbd = cfg_q[PBD_LSB +: 2];
   wire logic f_cko_dis = cfg_q[CKO_BIT];
   wire logic [1:0] f_pom = cfg_q[POM_LSB +: 2];
   wire logic f_tss = cfg_q[TSS_BIT];
   wire logic f_soe = cfg_q[SOE_BIT];
   wire logic [2:0] f_oss = cfg_q[OSS_LSB +: 3];

   // decoded pieces
   wire logic [3:0] pom_flags = posc_flags(f_pom);
   wire logic [7:0] oss_lane = src_lane(f_oss);
   wire logic rsv_ok = ((cfg_q & CFG_RESERVED_MASK) == CFG_RESERVED_MASK);
   wire logic posc_is_src = (f_oss == OCD_SRC_POSC) || (f_oss == OCD_SRC_POSC_PLL);
   // reported only: forcing a source here would hide a bad word from software
   wire logic posc_conflict = posc_is_src && pom_flags[3];

   // switching stays on for 0x, the monitor only for 00
   wire logic sw_en = !f_csm[1];
   wire logic fs_en = (f_csm == 2'h0);
   wire logic [3:0] pb_ratio = 4'h1 << f_pbd;
   // clock out only when no crystal sits on the oscillator pins
   wire logic cko_en = !f_cko_dis && (pom_flags[3] || pom_flags[0]);
   wire logic pll_used = (f_oss == OCD_SRC_POSC_PLL) || (f_oss == OCD_SRC_FAST_RC_DIVIDED_PLL);

   ocd_ctrl_s ctrl_d;
   assign ctrl_d = '{
      clock_switch_en: sw_en,
      fail_safe_en: fs_en,
      pb_div_ratio: pb_ratio,
      clock_output_en: cko_en,
      posc_off: pom_flags[3],
      posc_hs: pom_flags[2],
      posc_xt: pom_flags[1],
      posc_ext: pom_flags[0],
      two_speed_startup_en: f_tss,
      secondary_osc_en: f_soe,
      src_onehot: oss_lane,
      src_uses_pll: pll_used
   };

   // controls from flip-flops, safe values until capture completes
   // safe set: no switching, no monitor, undivided bus, fast rc source
   localparam ocd_ctrl_s CTRL_RESET = '{
      clock_switch_en: 1'b0,
      fail_safe_en: 1'b0,
      pb_div_ratio: PB_DIV_RESET,
      clock_output_en: 1'b0,
      posc_off: 1'b0,
      posc_hs: 1'b0,
      posc_xt: 1'b0,
      posc_ext: 1'b0,
      two_speed_startup_en: 1'b0,
      secondary_osc_en: 1'b0,
      src_onehot: SRC_ONEHOT_RESET,
      src_uses_pll: 1'b0
   };

   ocd_ctrl_s ctrl_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (cfg_valid_q) begin
         ctrl_q <= ctrl_d;
      end
   end
   assign ctrl_o = ctrl_q;
   assign cfg_valid_o = cfg_valid_q;

   // -----------------------------------------------------------------
   // register port
   // -----------------------------------------------------------------
   // all registers are read-only; writes are accepted and dropped
   // the control struct is 22 bits wide
   wire logic [31:0] ctrl_word = {10'h000, ctrl_q};
   wire logic [31:0] status_word = {29'h0, posc_conflict, rsv_ok, cfg_valid_q};
   logic [31:0] rsel;
   always_comb begin
      unique case (addr_i)
         ADDR_CFG_WORD: rsel = cfg_q;
         ADDR_DECODED: rsel = ctrl_word;
         ADDR_STATUS: rsel = status_word;
         default: rsel = RDATA_UNMAPPED;
      endcase
   end

   logic [31:0] rdata_q;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rd_i ? rsel : 32'h0000_0000;
      end
   end
   assign rdata_o = rdata_q;

   wire logic unused_ok = &{1'b0, wr_i, wdata_i};
endmodule

/* common/ocd_pkg.sv */
/*
 shared constants and types for the oscillator configuration decoder:
 field positions of the configuration word, codes, register map.
 assumes a single 10 MHz clock domain and a plain strobe register port.
*/
package ocd_pkg;
   // -----------------------------------------------------------------
   // configuration word field positions
   // -----------------------------------------------------------------
   localparam int CSM_LSB = 14;
   localparam int PBD_LSB = 12;
   localparam int RSV11_BIT = 11;
   localparam int CKO_BIT = 10;
   localparam int POM_LSB = 8;
   localparam int TSS_BIT = 7;
   localparam int RSV6_BIT = 6;
   localparam int SOE_BIT = 5;
   localparam int RSV4_BIT = 4;
   localparam int RSV3_BIT = 3;
   localparam int OSS_LSB = 0;
   localparam logic [31:0] CFG_RESERVED_MASK = 32'h0000_0858;

   // -----------------------------------------------------------------
   // register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG_WORD = 8'h00;
   localparam logic [7:0] ADDR_DECODED = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

   // -----------------------------------------------------------------
   // codes
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      OCD_POSC_EXT = 2'h0,
      OCD_POSC_XT = 2'h1,
      OCD_POSC_HS = 2'h2,
      OCD_POSC_OFF = 2'h3
   } ocd_posc_e;

   typedef enum logic [2:0] {
      OCD_SRC_FRC = 3'h0,
      OCD_SRC_FAST_RC_DIVIDED_PLL = 3'h1,
      OCD_SRC_POSC = 3'h2,
      OCD_SRC_POSC_PLL = 3'h3,
      OCD_SRC_SOSC = 3'h4,
      OCD_SRC_LOW_POWER_RC_OSC = 3'h5,
      OCD_SRC_FRC_DIV16 = 3'h6,
      OCD_SRC_FRC_DIVN = 3'h7
   } ocd_src_e;

   // one-hot source select toward the clock mux
   localparam logic [7:0] SRC_ONEHOT_RESET = 8'h01;

   typedef struct packed {
      logic clock_switch_en;
      logic fail_safe_en;
      logic [3:0] pb_div_ratio;
      logic clock_output_en;
      logic posc_off;
      logic posc_hs;
      logic posc_xt;
      logic posc_ext;
      logic two_speed_startup_en;
      logic secondary_osc_en;
      logic [7:0] src_onehot;
      logic src_uses_pll;
   } ocd_ctrl_s;

   localparam logic [3:0] PB_DIV_RESET = 4'h1;
endpackage

/* dv/ocd_decode_props.sv */
/*
 port checker for ocd_decode, bound into every instance.
 assumes cfg_word_i stays put while out of reset.
*/
`timescale 1ns/1ps
module ocd_decode_props
   import ocd_pkg::*;
(
   // watched ports
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [31:0] cfg_word_i,
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire ocd_pkg::ocd_ctrl_s ctrl_o,
   input wire logic cfg_valid_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // static word, so the live input is the reference
   wire logic [31:0] cw = cfg_word_i;
   // capture flag one edge late, once the controls have been loaded
   logic on;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         on <= 1'b0;
      end else begin
         on <= cfg_valid_o;
      end
   end
   a_switch_decode: assert property (on |->
      ctrl_o.clock_switch_en == !cw[15] && ctrl_o.fail_safe_en == (cw[15:14] == 2'h0)) else $error("switch");
   a_pbdiv_ratio: assert property (on |-> ctrl_o.pb_div_ratio == 4'h1 << cw[13:12]) else $error("div");
   a_clkout_gate: assert property (on |->
      ctrl_o.clock_output_en == (!cw[10] && cw[9] == cw[8])) else $error("clock out");
   a_posc_mode: assert property (on |->
      {ctrl_o.posc_off, ctrl_o.posc_hs, ctrl_o.posc_xt, ctrl_o.posc_ext} == 4'h1 << cw[9:8]) else $error("posc");
   a_two_speed: assert property (on |-> ctrl_o.two_speed_startup_en == cw[7]) else $error("two speed");
   a_sosc_enable: assert property (on |-> ctrl_o.secondary_osc_en == cw[5]) else $error("sosc");
   a_source_select: assert property (on |->
      ctrl_o.src_onehot == 8'h01 << cw[2:0] && ctrl_o.src_uses_pll == (!cw[2] && cw[0])) else $error("source");
   a_ctrl_frozen: assert property ($past(cfg_valid_o, 2) |-> $stable(ctrl_o) && cfg_valid_o) else $error("frozen");
   a_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rdata idle");
   c_status_read: cover property (rd_i && addr_i == ADDR_STATUS);
   c_clock_out: cover property (ctrl_o.clock_output_en);
   c_fail_safe: cover property (ctrl_o.fail_safe_en);
endmodule
bind ocd_decode ocd_decode_props u_props (.clock_i, .nrst_i, .cfg_word_i, .addr_i, .rd_i, .rdata_o, .ctrl_o,
   .cfg_valid_o);

/* dv/tb_ocd_decode.sv */
/*
 self-checking bench for ocd_decode: decode table, reset, reads.
 assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ps
module tb_ocd_decode;
   import ocd_pkg::*;
   logic clock_i = 0;
   logic nrst_i = 0;
   logic [31:0] cfg_word_i = 32'h0;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 0;
   logic rd_i = 0;
   logic [31:0] rdata_o;
   ocd_ctrl_s ctrl_o;
   logic cfg_valid_o;
   int n_fail = 0;
   int check_count = 0;
   // word beside the controls it must give
   logic [15:0] row_cfg [8] = '{16'h0858, 16'h5bd9, 16'hae7a, 16'hf9fb, 16'h085c, 16'h0c5d, 16'h085e, 16'h085f};
   logic [21:0] row_exp [8] = '{22'h318802, 22'h22c405, 22'h042208, 22'h081611, 22'h318820, 22'h310840,
      22'h318880, 22'h318900};
   ocd_decode uut (.clock_i, .nrst_i, .cfg_word_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .ctrl_o,
      .cfg_valid_o);
   initial forever #50 clock_i = ~clock_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // reset with a new word, wait bounded for capture and decode
   task automatic boot(input logic [31:0] w, input int hold);
      int i;
      @(posedge clock_i);
      nrst_i <= 1'b0;
      cfg_word_i <= w;
      repeat (hold) @(posedge clock_i);
      nrst_i <= 1'b1;
      for (i = 0; i < 20 && cfg_valid_o !== 1'b1; i++) begin
         @(posedge clock_i);
         #1;
      end
      if (i == 20) begin
         n_fail++;
         summarize();
      end
      @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock_i);
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      addr_i <= a;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      #1 chk({10'h0, ctrl_o}, 32'h10002);
      chk({31'h0, cfg_valid_o}, 32'h0);
      boot({16'h0, row_cfg[0]}, 6);
      for (int k = 0; k < 8; k++) begin
         boot({16'h0, row_cfg[k]}, 2);
         chk({10'h0, ctrl_o}, {10'h0, row_exp[k]});
      end
      rd(ADDR_STATUS, 32'h3);
      rd(ADDR_CFG_WORD, 32'h085f);
      // reserved bits clear, primary off yet chosen as source
      boot(32'h0000_0302, 2);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= ADDR_CFG_WORD;
      wdata_i <= 32'hffff_ffff;
      rd(ADDR_CFG_WORD, 32'h0302);
      rd(ADDR_STATUS, 32'h5);
      rd(8'h0c, RDATA_UNMAPPED);
      @(posedge clock_i);
      #1 chk(rdata_o, 32'h0);
      summarize();
   end
endmodule
